//--- bench/dead_time_pwm_wave_and_fault_inputs_test.sv
module dead_time_pwm_wave_and_fault_inputs_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 1'b0;
	logic        rstn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic        hreadyout, hresp, event_in_a, event_in_b;
	logic [31:0] hrdata;
	logic        wave_out_a, wave_out_b;
	logic        go_a = 1'b0;
	logic        pa = 1'b0; // output a one sample back
	logic [7:0]  len_a = 8'h0C; // event span in cycles
	integer      mode_now = 0;
	integer      mismatches = 0;
	integer      n_compared = 0;

	always #2 mclk = ~mclk;
	always @(posedge mclk) pa <= wave_out_a;

	dead_time_pwm uut (.mclk(mclk), .rstn(rstn), .ce(1'b1), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .event_in_a(event_in_a),
		.event_in_b(event_in_b), .wave_out_a(wave_out_a),
		.wave_out_b(wave_out_b));
	event_net net (.mclk(mclk), .go_a(go_a), .len_a(len_a),
		.event_in_a(event_in_a), .event_in_b(event_in_b));

	task finish_test;
	begin
		if (mismatches == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask

	// one single-word transfer, address phase then data phase
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
	begin
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		q = hrdata;
	end
	endtask

	// cycles between rises of output a, and cycles a was high
	task period(output integer n, output integer h);
	begin
		do @(posedge mclk); while (!(wave_out_a === 1'b1 && pa === 1'b0));
		n = 0;
		h = 0;
		do
		begin
			@(posedge mclk);
			n++;
			if (pa === 1'b1)
				h++;
		end while (!(wave_out_a === 1'b1 && pa === 1'b0));
	end
	endtask

	// outputs never both on outside dual slope
	always @(posedge mclk)
		if (rstn && wave_out_a === 1'b1 && wave_out_b === 1'b1
			&& mode_now != 3)
			chk(32'h1, 32'h0);

	// watchdog against a hung wait
	initial
	begin
		#100000;
		mismatches++;
		finish_test;
	end

	initial
	begin
		integer m, t, n, h, aon, aoff, bon, boff, ex, ev, dly;
		logic [31:0] q;
		void'($urandom(51));
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		bus(1'b0, 8'h04, 32'h0, q);
		chk(q, 32'h0); // compare resets to zero
		bus(1'b0, 8'h3C, 32'h0, q);
		chk(q, 32'h0); // unmapped reads zero
		chk(hresp, 32'h0); // okay response
		for (m = 0; m < 4; m++)
		begin
			// ascending compares, no blanking, no filter
			aon = $urandom_range(1, 8);
			aoff = aon + $urandom_range(2, 8);
			bon = aoff + $urandom_range(1, 8);
			boff = bon + $urandom_range(2, 8);
			mode_now = m;
			bus(1'b1, 8'h00, 32'h0, q);
			bus(1'b1, 8'h04, 32'hFFFF_F000 | aon, q);
			bus(1'b0, 8'h04, 32'h0, q);
			chk(q, aon); // twelve-bit field only
			bus(1'b1, 8'h08, aoff, q);
			bus(1'b1, 8'h0C, bon, q);
			bus(1'b1, 8'h10, boff, q);
			bus(1'b1, 8'h00, (m << 1) | 1, q);
			case (m)
				0: ex = boff + 1;
				1: ex = aoff + boff + 2;
				2: ex = aon + aoff + bon + boff + 4;
				default: ex = 2 * (boff + 1);
			endcase
			period(n, h);
			chk(n, ex);
			if (m == 0)
				chk(h, aoff - aon); // on phase a span
			if (m == 3)
			begin
				bus(1'b1, 8'h08, $urandom_range(0, 4095), q);
				period(n, h);
				chk(n, ex); // a off ignored in dual
			end
		end
		// fault on a while output a is on: trigger off, on, blanked,
		// unsynced, filtered, filtered short pulse
		bus(1'b1, 8'h00, 32'h0, q);
		bus(1'b1, 8'h04, 32'h1, q);
		mode_now = 0;
		bus(1'b1, 8'h08, 32'h28, q);
		bus(1'b1, 8'h0C, 32'h29, q);
		bus(1'b1, 8'h10, 32'h2A, q);
		bus(1'b1, 8'h20, 32'h20, q);
		bus(1'b1, 8'h00, 32'h1, q);
		for (t = 0; t < 6; t++)
		begin
			ev = (t == 0) ? 0 : (t == 3) ? 9 : (t >= 4) ? 5 : 1;
			dly = (t == 2) ? 5 : 0;
			bus(1'b1, 8'h14, ev, q);
			bus(1'b1, 8'h1C, dly, q);
			len_a <= (t == 5) ? 8'h03 : 8'h0C;
			ex = (t == 0 || t == 2 || t == 5);
			do @(posedge mclk); while (!(wave_out_a === 1'b1 && pa === 1'b0));
			go_a <= 1'b1;
			@(posedge mclk);
			go_a <= 1'b0;
			repeat ((t == 4) ? 7 : 3) @(posedge mclk);
			repeat (8)
			begin
				@(posedge mclk);
				chk(wave_out_a, ex);
			end
		end
		finish_test;
	end
endmodule

//--- bench/event_net.sv
// event routing model: drives fault input a for a requested span
module event_net
(
	input  wire logic       mclk,
	input  wire logic       go_a,
	input  wire logic [7:0] len_a,
	output logic            event_in_a,
	output logic            event_in_b
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_r = 8'h00; // cycles of event left

	// load on request, count down while high
	always @(posedge mclk)
	begin
		if (go_a)
			cnt_r <= len_a;
		else if (cnt_r != 8'h00)
			cnt_r <= cnt_r - 8'h01;
	end
	assign event_in_a = (cnt_r != 8'h00); // level event
	assign event_in_b = 1'b0;             // input b quiet
endmodule

//--- common/dtpwm_defines.svh
`ifndef DTPWM_DEFINES_SVH
`define DTPWM_DEFINES_SVH

// register byte offsets on the bus
`define OFS_CTRL        8'h00
`define OFS_CMP_A_ON    8'h04
`define OFS_CMP_A_OFF   8'h08
`define OFS_CMP_B_ON    8'h0C
`define OFS_CMP_B_OFF   8'h10
`define OFS_EVCTRL_A    8'h14
`define OFS_EVCTRL_B    8'h18
`define OFS_DLY_CTRL    8'h1C
`define OFS_DLY_VAL     8'h20
`define OFS_STATUS      8'h24
`define OFS_CAPTURE_A   8'h28
`define OFS_CAPTURE_B   8'h2C

// control register fields
`define CTRL_EN_BIT     0
`define CTRL_MODE_LSB   1

// event control fields
`define EV_TRIG_BIT     0
`define EV_ACTION_BIT   1
`define EV_FILTER_BIT   2
`define EV_UNSYNCED_DETECT_ENABLE_BIT    3

// delay control fields
`define DLY_SEL_LSB     0
`define DLY_TRIG_LSB    2
`define DLY_PRESC_LSB   4
`define DLY_SEL_BLANK   2'h1

// status register fields
`define ST_PHASE_LSB    12
`define ST_WAVE_A_BIT   16
`define ST_WAVE_B_BIT   17
`define ST_DIR_BIT      18
`define ST_BLANK_BIT    19

// reset values and counts
`define RST_WORD        32'h0000_0000
`define RST_CMP         12'h000
`define FILTER_CYCLES   4

`endif

//--- common/dtpwm_pkg.sv
package dtpwm_pkg;

	// counting scheme of one waveform cycle
	typedef enum logic [1:0]
	{
		one_ramp  = 2'h0,
		two_ramp  = 2'h1,
		four_ramp = 2'h2,
		dual_slope = 2'h3
	} waveform_mode_sel_t;

	// phases of a waveform cycle, one-hot
	typedef enum logic [3:0]
	{
		dead_phase_a = 4'h1,
		on_phase_a   = 4'h2,
		dead_phase_b = 4'h4,
		on_phase_b   = 4'h8
	} phase_t;

endpackage

//--- core/dead_time_pwm.sv
`include "dtpwm_defines.svh"

// Summary of operation
// - mode field picks one of four counting schemes
// - cycle runs dead A, on A, dead B, on B
// - one ramp: count to B off, restart zero
// - one ramp: compares above B off never match
// - one ramp: A off below A on ignored
// - two ramp: ramp to A off, then B off
// - two ramp: outputs never both active
// - four ramp: four ramps ending at each compare
// - four ramp: outputs never overlap
// - dual slope: down from B off and back
// - dual slope: A on rising, off falling match
// - dual slope: B on falling, off rising match
// - dual slope: A off compare is ignored
// - dual start at top down, A held off
// - input acts when enabled, captures on action
// - blanking only on input A
// - synced input overrides outputs within 2 cycles
// - blanking on when delay select is one
// - blanking lasts delay value divided ticks
// - filter rejects pulses under four clocks
// - unsynced detect overrides outputs at the next clock
module dead_time_pwm
	import dtpwm_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic        event_in_a,
	input  wire logic        event_in_b,
	output logic             wave_out_a,
	output logic             wave_out_b
);

	// bus state
	logic [7:0]  addr_r, addr_nxt;          // data phase address
	logic        wr_r, wr_nxt;              // write data phase
	logic        rd_r, rd_nxt;              // read wait state
	logic        hreadyout_r, hreadyout_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;
	logic        hresp_r;                   // always okay
	logic [31:0] rd_word;                   // read mux

	// software registers
	logic               enable_r, enable_nxt;
	waveform_mode_sel_t mode_r, mode_nxt;
	logic [11:0]        compare_a_on_value_r, compare_a_on_value_nxt;
	logic [11:0]        compare_a_off_value_r, compare_a_off_value_nxt;
	logic [11:0]        compare_b_on_value_r, compare_b_on_value_nxt;
	logic [11:0]        compare_b_off_value_r, compare_b_off_value_nxt;
	logic [3:0]         input_a_event_control_r, input_a_event_control_nxt;
	logic [3:0]         input_b_event_control_r, input_b_event_control_nxt;
	logic [5:0]         delay_control_r, delay_control_nxt;
	logic [7:0]         delay_count_value_r, delay_count_value_nxt;

	// waveform state
	logic [11:0] cnt_r, cnt_nxt;            // counter
	phase_t      phase_r, phase_nxt;        // cycle phase
	logic        dir_r, dir_nxt;            // dual slope: 1 counts up
	logic        a_ds_r, a_ds_nxt;          // dual slope A level
	logic        b_ds_r, b_ds_nxt;          // dual slope B level
	logic        primed_r, primed_nxt;      // first dual cycle done
	logic        wave_a, wave_b;            // unguarded levels
	logic        wave_out_a_r, wave_out_a_nxt;
	logic        wave_out_b_r, wave_out_b_nxt;

	// input front end
	logic        ev_raw [2];                // raw event levels
	logic [3:0]  evc [2];                   // event controls
	logic        ev_s_r [2];                // registered input
	logic [2:0]  sh_r [2];                  // filter history
	logic        filt_r [2];                // filtered level
	logic        sel_d_r [2];               // previous level
	logic [11:0] cap_r [2];                 // captured counter
	logic        blank [2];                 // blanking per input
	logic        kill [2];                  // output override
	logic        blank_start;               // window trigger
	logic        blank_act;                 // window open

	assign ev_raw[0] = event_in_a;
	assign ev_raw[1] = event_in_b;
	assign evc[0] = input_a_event_control_r;
	assign evc[1] = input_b_event_control_r;
	assign blank[0] = blank_act;
	assign blank[1] = 1'b0;

	assign hreadyout = hreadyout_r;
	assign hrdata = hrdata_r;
	assign hresp = hresp_r;
	assign wave_out_a = wave_out_a_r;
	assign wave_out_b = wave_out_b_r;

	// phase that follows a given phase
	function automatic phase_t next_phase(input phase_t p);
		unique case (p)
			dead_phase_a: next_phase = on_phase_a;
			on_phase_a:   next_phase = dead_phase_b;
			dead_phase_b: next_phase = on_phase_b;
			default:      next_phase = dead_phase_a;
		endcase
	endfunction

	// compare that ends a phase in four ramp
	function automatic logic [11:0] phase_limit(input phase_t p,
		input logic [11:0] a_on, input logic [11:0] a_off,
		input logic [11:0] b_on, input logic [11:0] b_off);
		unique case (p)
			dead_phase_a: phase_limit = a_on;
			on_phase_a:   phase_limit = a_off;
			dead_phase_b: phase_limit = b_on;
			default:      phase_limit = b_off;
		endcase
	endfunction

	// read mux of all registers
	always_comb
	begin
		rd_word = `RST_WORD;
		unique case (addr_r)
			`OFS_CTRL:
			begin
				rd_word[`CTRL_EN_BIT] = enable_r;
				rd_word[`CTRL_MODE_LSB +: 2] = mode_r;
			end
			`OFS_CMP_A_ON:  rd_word[11:0] = compare_a_on_value_r;
			`OFS_CMP_A_OFF: rd_word[11:0] = compare_a_off_value_r;
			`OFS_CMP_B_ON:  rd_word[11:0] = compare_b_on_value_r;
			`OFS_CMP_B_OFF: rd_word[11:0] = compare_b_off_value_r;
			`OFS_EVCTRL_A:  rd_word[3:0] = input_a_event_control_r;
			`OFS_EVCTRL_B:  rd_word[3:0] = input_b_event_control_r;
			`OFS_DLY_CTRL:  rd_word[5:0] = delay_control_r;
			`OFS_DLY_VAL:   rd_word[7:0] = delay_count_value_r;
			`OFS_STATUS:
			begin
				rd_word[11:0] = cnt_r;
				rd_word[`ST_PHASE_LSB +: 4] = phase_r;
				rd_word[`ST_WAVE_A_BIT] = wave_out_a_r;
				rd_word[`ST_WAVE_B_BIT] = wave_out_b_r;
				rd_word[`ST_DIR_BIT] = dir_r;
				rd_word[`ST_BLANK_BIT] = blank_act;
			end
			`OFS_CAPTURE_A: rd_word[11:0] = cap_r[0];
			`OFS_CAPTURE_B: rd_word[11:0] = cap_r[1];
			default:        rd_word = `RST_WORD;   // unmapped reads zero
		endcase
	end

	// bus slave and register writes
	always_comb
	begin
		addr_nxt = addr_r;
		wr_nxt = 1'b0;
		rd_nxt = 1'b0;
		hreadyout_nxt = 1'b1;
		hrdata_nxt = hrdata_r;
		enable_nxt = enable_r;
		mode_nxt = mode_r;
		compare_a_on_value_nxt = compare_a_on_value_r;
		compare_a_off_value_nxt = compare_a_off_value_r;
		compare_b_on_value_nxt = compare_b_on_value_r;
		compare_b_off_value_nxt = compare_b_off_value_r;
		input_a_event_control_nxt = input_a_event_control_r;
		input_b_event_control_nxt = input_b_event_control_r;
		delay_control_nxt = delay_control_r;
		delay_count_value_nxt = delay_count_value_r;
		// write data phase
		if (wr_r)
		begin
			unique case (addr_r)
				`OFS_CTRL:
				begin
					enable_nxt = hwdata[`CTRL_EN_BIT];
					mode_nxt = waveform_mode_sel_t'(hwdata[2:1]);
				end
				`OFS_CMP_A_ON:  compare_a_on_value_nxt = hwdata[11:0];
				`OFS_CMP_A_OFF: compare_a_off_value_nxt = hwdata[11:0];
				`OFS_CMP_B_ON:  compare_b_on_value_nxt = hwdata[11:0];
				`OFS_CMP_B_OFF: compare_b_off_value_nxt = hwdata[11:0];
				`OFS_EVCTRL_A:  input_a_event_control_nxt = hwdata[3:0];
				`OFS_EVCTRL_B:  input_b_event_control_nxt = hwdata[3:0];
				`OFS_DLY_CTRL:  delay_control_nxt = hwdata[5:0];
				`OFS_DLY_VAL:   delay_count_value_nxt = hwdata[7:0];
				default:        wr_nxt = 1'b0;    // read-only or unmapped
			endcase
		end
		// read wait state: data taken after any prior write
		if (rd_r)
			hrdata_nxt = rd_word;
		// address phase
		if (hsel && hready && htrans[1])
		begin
			addr_nxt = haddr[7:0];
			wr_nxt = hwrite;
			rd_nxt = !hwrite;
			hreadyout_nxt = hwrite;
		end
	end

	// bus and register flops
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			addr_r <= 8'h00;
			wr_r <= 1'b0;
			rd_r <= 1'b0;
			hreadyout_r <= 1'b1;
			hrdata_r <= `RST_WORD;
			hresp_r <= 1'b0;
			enable_r <= 1'b0;
			mode_r <= one_ramp;
			compare_a_on_value_r <= `RST_CMP;
			compare_a_off_value_r <= `RST_CMP;
			compare_b_on_value_r <= `RST_CMP;
			compare_b_off_value_r <= `RST_CMP;
			input_a_event_control_r <= 4'h0;
			input_b_event_control_r <= 4'h0;
			delay_control_r <= 6'h00;
			delay_count_value_r <= 8'h00;
		end
		else if (ce)
		begin
			addr_r <= addr_nxt;
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			hreadyout_r <= hreadyout_nxt;
			hrdata_r <= hrdata_nxt;
			hresp_r <= 1'b0;
			enable_r <= enable_nxt;
			mode_r <= mode_nxt;
			compare_a_on_value_r <= compare_a_on_value_nxt;
			compare_a_off_value_r <= compare_a_off_value_nxt;
			compare_b_on_value_r <= compare_b_on_value_nxt;
			compare_b_off_value_r <= compare_b_off_value_nxt;
			input_a_event_control_r <= input_a_event_control_nxt;
			input_b_event_control_r <= input_b_event_control_nxt;
			delay_control_r <= delay_control_nxt;
			delay_count_value_r <= delay_count_value_nxt;
		end
	end

	// counter and phase sequencing
	always_comb
	begin
		cnt_nxt = cnt_r + 12'h001;              // wraps in 12 bits
		phase_nxt = phase_r;
		dir_nxt = dir_r;
		a_ds_nxt = a_ds_r;
		b_ds_nxt = b_ds_r;
		primed_nxt = primed_r;
		if (!enable_r)
		begin
			// idle: dual slope waits at the top, counting down
			// follows a pending write, so enabling starts at the top
			cnt_nxt = (mode_nxt == dual_slope)
				? compare_b_off_value_nxt : 12'h000;
			phase_nxt = dead_phase_a;
			dir_nxt = 1'b0;
			a_ds_nxt = 1'b0;
			b_ds_nxt = 1'b0;
			primed_nxt = 1'b0;
		end
		else
		begin
			unique case (mode_r)
				one_ramp:
				begin
					// phases advance only in order
					if ((phase_r == dead_phase_a
						&& cnt_r == compare_a_on_value_r)
						|| (phase_r == on_phase_a
						&& cnt_r == compare_a_off_value_r)
						|| (phase_r == dead_phase_b
						&& cnt_r == compare_b_on_value_r))
						phase_nxt = next_phase(phase_r);
					if (cnt_r == compare_b_off_value_r)
					begin
						cnt_nxt = 12'h000;
						phase_nxt = dead_phase_a;
					end
				end
				two_ramp:
				begin
					// on phase starts at the set match of its ramp
					if ((phase_r == dead_phase_a
						&& cnt_r == compare_a_on_value_r)
						|| (phase_r == dead_phase_b
						&& cnt_r == compare_b_on_value_r))
						phase_nxt = next_phase(phase_r);
					if ((phase_r == dead_phase_a || phase_r == on_phase_a)
						&& cnt_r == compare_a_off_value_r)
					begin
						cnt_nxt = 12'h000;
						phase_nxt = dead_phase_b;
					end
					if ((phase_r == dead_phase_b || phase_r == on_phase_b)
						&& cnt_r == compare_b_off_value_r)
					begin
						cnt_nxt = 12'h000;
						phase_nxt = dead_phase_a;
					end
				end
				four_ramp:
				begin
					// each phase is one ramp from zero
					if (cnt_r == phase_limit(phase_r,
						compare_a_on_value_r, compare_a_off_value_r,
						compare_b_on_value_r, compare_b_off_value_r))
					begin
						cnt_nxt = 12'h000;
						phase_nxt = next_phase(phase_r);
					end
				end
				dual_slope:
				begin
					// the A off compare is never read here
					if (!dir_r)
					begin
						if (cnt_r == compare_a_on_value_r)
							a_ds_nxt = 1'b0;
						if (cnt_r == compare_b_on_value_r)
							b_ds_nxt = 1'b1;
						if (cnt_r == 12'h000)
						begin
							cnt_nxt = cnt_r;    // bottom held once
							dir_nxt = 1'b1;
						end
						else
							cnt_nxt = cnt_r - 12'h001;
					end
					else
					begin
						if (cnt_r == compare_a_on_value_r && primed_r)
							a_ds_nxt = 1'b1;
						if (cnt_r == compare_b_on_value_r)
							b_ds_nxt = 1'b0;
						if (cnt_r == compare_b_off_value_r)
						begin
							cnt_nxt = cnt_r;    // top ends the cycle
							dir_nxt = 1'b0;
							primed_nxt = 1'b1;
						end
					end
					phase_nxt = a_ds_nxt ? on_phase_a : b_ds_nxt ? on_phase_b
						: dir_nxt ? dead_phase_a : dead_phase_b;
				end
			endcase
		end
	end

	// output levels, ramp modes cannot overlap
	assign wave_a = (mode_r == dual_slope) ? a_ds_r : phase_r == on_phase_a;
	assign wave_b = (mode_r == dual_slope) ? b_ds_r : phase_r == on_phase_b;

	// fault override of the outputs
	always_comb
	begin
		wave_out_a_nxt = enable_r && wave_a && !kill[0];
		wave_out_b_nxt = enable_r && wave_b && !kill[1];
	end

	// waveform flops
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			cnt_r <= 12'h000;
			phase_r <= dead_phase_a;
			dir_r <= 1'b0;
			a_ds_r <= 1'b0;
			b_ds_r <= 1'b0;
			primed_r <= 1'b0;
			wave_out_a_r <= 1'b0;
			wave_out_b_r <= 1'b0;
		end
		else if (ce)
		begin
			cnt_r <= cnt_nxt;
			phase_r <= phase_nxt;
			dir_r <= dir_nxt;
			a_ds_r <= a_ds_nxt;
			b_ds_r <= b_ds_nxt;
			primed_r <= primed_nxt;
			wave_out_a_r <= wave_out_a_nxt;
			wave_out_b_r <= wave_out_b_nxt;
		end
	end

	// blanking window starts on entry to the chosen phase
	assign blank_start = delay_control_r[`DLY_SEL_LSB +: 2] == `DLY_SEL_BLANK
		&& phase_nxt != phase_r && enable_r
		&& phase_nxt == phase_t'(4'h1 << delay_control_r[`DLY_TRIG_LSB +: 2]);

	// window timer on the divided delay clock
	delay_counter u_delay
	(
		.mclk   (mclk),
		.rstn   (rstn),
		.ce     (ce),
		.start  (blank_start),
		.presc  (delay_control_r[`DLY_PRESC_LSB +: 2]),
		.limit  (delay_count_value_r),
		.active (blank_act)
	);

	// per-input front end: register, filter, capture
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_in
			logic       sel_lvl;    // synced or filtered level
			logic       filt_nxt;
			logic       cap_hit;

			// filter settles after four equal samples
			always_comb
			begin
				filt_nxt = filt_r[gi];
				if (ev_s_r[gi] && (&sh_r[gi]))
					filt_nxt = 1'b1;
				else if (!ev_s_r[gi] && !(|sh_r[gi]))
					filt_nxt = 1'b0;
				sel_lvl = evc[gi][`EV_FILTER_BIT] ? filt_r[gi] : ev_s_r[gi];
				// capture on a rising trigger with action set
				cap_hit = evc[gi][`EV_TRIG_BIT] && evc[gi][`EV_ACTION_BIT]
					&& sel_lvl && !sel_d_r[gi];
				// synced path, or raw path when unsynced
				kill[gi] = evc[gi][`EV_TRIG_BIT] && !blank[gi]
					&& (sel_lvl || (evc[gi][`EV_UNSYNCED_DETECT_ENABLE_BIT] && ev_raw[gi]));
			end

			always_ff @(posedge mclk)
			begin
				if (!rstn)
				begin
					ev_s_r[gi] <= 1'b0;
					sh_r[gi] <= 3'h0;
					filt_r[gi] <= 1'b0;
					sel_d_r[gi] <= 1'b0;
					cap_r[gi] <= 12'h000;
				end
				else if (ce)
				begin
					ev_s_r[gi] <= ev_raw[gi];
					sh_r[gi] <= {sh_r[gi][1:0], ev_s_r[gi]};
					filt_r[gi] <= filt_nxt;
					sel_d_r[gi] <= sel_lvl;
					cap_r[gi] <= cap_hit ? cnt_r : cap_r[gi];
				end
			end

			property p_filter_hold;
				@(posedge mclk) disable iff (!rstn || !ce)
				$rose(filt_r[gi]) |-> $past(ev_s_r[gi], 1)
					&& $past(ev_s_r[gi], 2) && $past(ev_s_r[gi], 4);
			endproperty
			a_filter_hold: assert property (p_filter_hold)
				else $error("filter passed a short pulse");
		end
	endgenerate

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn || !ce);

	sequence s_one_top;
		enable_r && mode_r == one_ramp && cnt_r == compare_b_off_value_r;
	endsequence
	sequence s_dual_top;
		enable_r && mode_r == dual_slope && dir_r
			&& cnt_r == compare_b_off_value_r;
	endsequence
	sequence s_fault_a;
		enable_r && evc[0][`EV_TRIG_BIT] && !blank_act
			&& !evc[0][`EV_FILTER_BIT] && ev_s_r[0];
	endsequence

	property p_one_wrap;
		s_one_top |=> cnt_r == 12'h000 && phase_r == dead_phase_a;
	endproperty
	a_one_wrap: assert property (p_one_wrap)
		else $error("one ramp did not restart at zero");

	property p_no_overlap;
		mode_r != one_ramp && mode_r != dual_slope && $stable(mode_r)
			|-> !(wave_out_a_r && wave_out_b_r);
	endproperty
	a_no_overlap: assert property (p_no_overlap)
		else $error("outputs overlap in a multi ramp mode");

	property p_dual_turn;
		s_dual_top |=> !dir_r ##1 cnt_r == compare_b_off_value_r - 12'h001
			|| compare_b_off_value_r == 12'h000;
	endproperty
	a_dual_turn: assert property (p_dual_turn)
		else $error("dual slope did not turn at the top");

	property p_dual_primed;
		enable_r && mode_r == dual_slope && !primed_r |=> !a_ds_r;
	endproperty
	a_dual_primed: assert property (p_dual_primed)
		else $error("output A set in first dual cycle");

	property p_dual_start;
		$rose(enable_r) && mode_r == dual_slope
			|-> cnt_r == compare_b_off_value_r && !dir_r;
	endproperty
	a_dual_start: assert property (p_dual_start)
		else $error("dual slope did not start at the top");

	property p_fault_a;
		s_fault_a |=> !wave_out_a_r;
	endproperty
	a_fault_a: assert property (p_fault_a)
		else $error("fault on input A did not stop output A");

	property p_unsynced_detect_enable_a;
		enable_r && evc[0][`EV_TRIG_BIT] && evc[0][`EV_UNSYNCED_DETECT_ENABLE_BIT]
			&& !blank_act && event_in_a |=> !wave_out_a_r;
	endproperty
	a_unsynced_detect_enable_a: assert property (p_unsynced_detect_enable_a)
		else $error("unsynced event did not stop output A");

	property p_four_step;
		enable_r && mode_r == four_ramp && phase_r == dead_phase_a
			&& cnt_r == compare_a_on_value_r
			|=> phase_r == on_phase_a && cnt_r == 12'h000;
	endproperty
	a_four_step: assert property (p_four_step)
		else $error("four ramp did not step to on phase A");

	property p_two_half;
		enable_r && mode_r == two_ramp && phase_r == on_phase_a
			&& cnt_r == compare_a_off_value_r
			|=> phase_r == dead_phase_b && cnt_r == 12'h000;
	endproperty
	a_two_half: assert property (p_two_half)
		else $error("two ramp did not switch ramps at A off");

endmodule

//--- core/delay_counter.sv
`include "dtpwm_defines.svh"

// blanking window timer on a divided clock
module delay_counter
(
	input  wire logic       mclk,    // system clock
	input  wire logic       rstn,    // synchronous reset, low active
	input  wire logic       ce,      // clock enable
	input  wire logic       start,   // trigger pulse, restarts window
	input  wire logic [1:0] presc,   // divide by 1, 2, 4 or 8
	input  wire logic [7:0] limit,   // window length in divided ticks
	output logic            active   // window open
);

	logic [7:0] div_r, div_nxt;     // prescaler count
	logic [7:0] cnt_r, cnt_nxt;     // divided tick count
	logic       act_r, act_nxt;     // window state
	logic [7:0] factor;             // division factor

	assign factor = 8'h01 << presc;
	assign active = act_r;

	// next state of the window timer
	always_comb
	begin
		div_nxt = div_r;
		cnt_nxt = cnt_r;
		act_nxt = act_r;
		if (start)
		begin
			// a zero limit opens no window
			act_nxt = (limit != 8'h00);
			cnt_nxt = 8'h00;
			div_nxt = 8'h00;
		end
		else if (act_r)
		begin
			if (div_r == factor - 8'h01)
			begin
				div_nxt = 8'h00;
				cnt_nxt = cnt_r + 8'h01;
				if (cnt_r + 8'h01 == limit)
					act_nxt = 1'b0;
			end
			else
				div_nxt = div_r + 8'h01;
		end
	end

	// registers, frozen while ce is low
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			div_r <= 8'h00;
			cnt_r <= 8'h00;
			act_r <= 1'b0;
		end
		else if (ce)
		begin
			div_r <= div_nxt;
			cnt_r <= cnt_nxt;
			act_r <= act_nxt;
		end
	end

endmodule
